// [src/watchdog_countdown_timer.sv]
`timescale 1ns/1ps
module watchdog_countdown_timer #(
    parameter int CLK_HZ = wdt_timer_pkg::CLK_HZ_DEFAULT,
    parameter int RST_FAST_CYC = wdt_timer_pkg::RST_W_FAST_CYC,
    parameter int RST_SLOW_CYC = wdt_timer_pkg::RST_W_SLOW_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // enables from the interrupt controller
    input wire logic second_event_enable,
    input wire logic minute_event_enable,
    input wire logic countdown_irq_enable,
    // outputs to the host
    output logic irq_n,
    output logic wdt_rst_n
);
    localparam int ACC_W = 32;
    localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(wdt_timer_pkg::FAST_TICK_HZ);
    localparam logic [ACC_W-1:0] ACC_TOP = ACC_W'(CLK_HZ);
    localparam int RW = wdt_timer_pkg::RST_CNT_W;
    localparam int IW = wdt_timer_pkg::IRQ_CNT_W;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    wdt_timer_pkg::mode_ctrl_s ctrl;
    wdt_timer_pkg::flags_s flags;
    logic [7:0] period_n;
    logic [7:0] cnt;
    logic wdt_done;
    logic first_skip;
    logic [RW-1:0] rst_cnt;
    logic [IW-1:0] irq_cnt;
    logic [ACC_W-1:0] acc;
    logic tick_4k;
    logic tick_64;
    logic tick_1;
    logic tick_min;

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    wire wr_ctrl = reg_wr && (reg_addr == wdt_timer_pkg::ADDR_MODE_CTRL);
    wire wr_period = reg_wr && (reg_addr == wdt_timer_pkg::ADDR_PERIOD);
    wire wr_flags = reg_wr && (reg_addr == wdt_timer_pkg::ADDR_FLAGS);
    wire rd_flags = reg_rd && (reg_addr == wdt_timer_pkg::ADDR_FLAGS);

    wdt_timer_pkg::timer_fn_e fn;
    wdt_timer_pkg::tick_src_e src;
    assign fn = ctrl.timer_function_select;
    assign src = ctrl.tick_source_select;

    wire mode_cd = (fn == wdt_timer_pkg::FN_COUNTDOWN);
    wire mode_wdt_irq = (fn == wdt_timer_pkg::FN_WDT_IRQ);
    wire mode_wdt_rst = (fn == wdt_timer_pkg::FN_WDT_RST);
    wire mode_wdt = mode_wdt_irq || mode_wdt_rst;

    // ------------------------------------------------------------
    // tick prescaler
    // ------------------------------------------------------------
    // fractional accumulator keeps 4096 Hz exact from a non-multiple clock
    wire [ACC_W-1:0] acc_sum = acc + ACC_STEP;
    wire acc_wrap = (acc_sum >= ACC_TOP);
    wire [ACC_W-1:0] next_acc = acc_wrap ? (acc_sum - ACC_TOP) : acc_sum;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            acc <= '0;
            tick_4k <= 1'b0;
        end else begin
            acc <= next_acc;
            tick_4k <= acc_wrap;
        end
    end

    tick_divider #(
        .RATIO(wdt_timer_pkg::DIV_TO_64HZ)
    ) u_div_64hz (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_tick(tick_4k),
        .out_tick(tick_64)
    );

    tick_divider #(
        .RATIO(wdt_timer_pkg::DIV_TO_1HZ)
    ) u_div_1hz (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_tick(tick_64),
        .out_tick(tick_1)
    );

    tick_divider #(
        .RATIO(wdt_timer_pkg::DIV_TO_MINUTE)
    ) u_div_min (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_tick(tick_1),
        .out_tick(tick_min)
    );

    // ------------------------------------------------------------
    // timer tick select
    // ------------------------------------------------------------
    logic timer_tick;
    always_comb begin
        unique case (src)
            wdt_timer_pkg::SRC_4096HZ: timer_tick = tick_4k;
            wdt_timer_pkg::SRC_64HZ: timer_tick = tick_64;
            wdt_timer_pkg::SRC_1HZ: timer_tick = tick_1;
            wdt_timer_pkg::SRC_1_60HZ: timer_tick = tick_min;
        endcase
    end

    // ------------------------------------------------------------
    // first period alignment
    // ------------------------------------------------------------
    // the prescaler runs free, so a fast tick can land just after a start;
    // swallowing it keeps the first period between n and n+1 ticks.
    // slow sources keep their first tick: that period may run short
    wdt_timer_pkg::mode_ctrl_s wr_view;
    assign wr_view = reg_wdata;
    wire start_cd = (wr_ctrl && !mode_cd
        && (wr_view.timer_function_select == wdt_timer_pkg::FN_COUNTDOWN))
        || (wr_period && mode_cd && (cnt == 8'h00));
    wire fast_src = (src == wdt_timer_pkg::SRC_4096HZ) || (src == wdt_timer_pkg::SRC_64HZ);
    wire skip_tick = first_skip && fast_src && mode_cd;
    wire count_tick = timer_tick && !skip_tick;

    logic next_first_skip;
    always_comb begin
        if (start_cd) begin
            next_first_skip = 1'b1;
        end else if (timer_tick) begin
            next_first_skip = 1'b0;
        end else begin
            next_first_skip = first_skip;
        end
    end

    // ------------------------------------------------------------
    // shared down-counter
    // ------------------------------------------------------------
    // one decrement per counted tick gives n ticks per period;
    // a new n loads at once, so the period it cuts into may run short
    wire running = (mode_cd || mode_wdt) && !wdt_done && (cnt != 8'h00);
    wire at_one = (cnt == 8'h01);
    wire expire = count_tick && running && at_one && !wr_period;
    wire wdt_expire = expire && mode_wdt;
    wire cd_expire = expire && mode_cd;

    logic [7:0] next_cnt;
    always_comb begin
        if (wr_period) begin
            next_cnt = reg_wdata;
        end else if (fn == wdt_timer_pkg::FN_OFF) begin
            next_cnt = period_n;
        end else if (count_tick && running) begin
            if (at_one) begin
                next_cnt = mode_cd ? period_n : cnt;
            end else begin
                next_cnt = cnt - 8'h01;
            end
        end else begin
            next_cnt = cnt;
        end
    end

    wire next_wdt_done = wdt_expire ? 1'b1 :
        (wr_period || !mode_wdt) ? 1'b0 : wdt_done;

    // ------------------------------------------------------------
    // second and minute events
    // ------------------------------------------------------------
    // driven from the 64 Hz chain, never from the shared counter
    wire sec_ev = tick_1 && second_event_enable;
    wire min_ev = tick_min && minute_event_enable;
    wire ms_ev = sec_ev || min_ev;

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    // set wins over a clear in the same cycle
    wire next_msf = ms_ev ||
        (flags.min_sec_flag && !(wr_flags && !reg_wdata[wdt_timer_pkg::FLAG_MSF_BIT]));
    wire next_countdown_expiry_flag = cd_expire ||
        (flags.countdown_expiry_flag
         && !(wr_flags && !reg_wdata[wdt_timer_pkg::FLAG_COUNTDOWN_EXPIRY_FLAG_BIT]));
    // flag register writes do not touch this one
    wire next_watchdog_expiry_flag = wdt_expire ||
        (flags.watchdog_expiry_flag && !wr_period && !rd_flags);

    // ------------------------------------------------------------
    // reset output pulse
    // ------------------------------------------------------------
    wire [RW-1:0] rst_width = (src == wdt_timer_pkg::SRC_4096HZ) ?
        RW'(RST_FAST_CYC) : RW'(RST_SLOW_CYC);

    logic [RW-1:0] next_rst_cnt;
    always_comb begin
        if (wr_period) begin
            next_rst_cnt = '0;
        end else if (wdt_expire && mode_wdt_rst) begin
            next_rst_cnt = rst_width;
        end else if (rst_cnt != '0) begin
            next_rst_cnt = rst_cnt - 1'b1;
        end else begin
            next_rst_cnt = rst_cnt;
        end
    end

    // ------------------------------------------------------------
    // interrupt output
    // ------------------------------------------------------------
    wire cd_irq_en = mode_cd && countdown_irq_enable;
    wire steady_src = flags.min_sec_flag
        || (flags.countdown_expiry_flag && cd_irq_en);
    wire pulse_trig = ms_ev || (cd_expire && cd_irq_en);

    logic [IW-1:0] next_irq_cnt;
    always_comb begin
        if (ctrl.irq_pulse_style && pulse_trig) begin
            next_irq_cnt = IW'(wdt_timer_pkg::IRQ_PULSE_CYC);
        end else if (irq_cnt != '0) begin
            next_irq_cnt = irq_cnt - 1'b1;
        end else begin
            next_irq_cnt = irq_cnt;
        end
    end

    // watchdog expiry is always a level, regardless of style
    wire wdt_irq = next_watchdog_expiry_flag && mode_wdt_irq;
    wire irq_active = wdt_irq
        || (ctrl.irq_pulse_style ? (next_irq_cnt != '0) : steady_src);

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [7:0] flag_view;
    always_comb begin
        flag_view = 8'h00;
        flag_view[wdt_timer_pkg::FLAG_MSF_BIT] = flags.min_sec_flag;
        flag_view[wdt_timer_pkg::FLAG_WATCHDOG_EXPIRY_FLAG_BIT] = flags.watchdog_expiry_flag;
        flag_view[wdt_timer_pkg::FLAG_COUNTDOWN_EXPIRY_FLAG_BIT] = flags.countdown_expiry_flag;
    end

    logic [7:0] rd_mux;
    always_comb begin
        unique case (reg_addr)
            wdt_timer_pkg::ADDR_FLAGS: rd_mux = flag_view;
            wdt_timer_pkg::ADDR_MODE_CTRL: rd_mux = {ctrl[7:5], 3'b000, ctrl[1:0]};
            wdt_timer_pkg::ADDR_PERIOD: rd_mux = cnt;
            default: rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // control and period registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl <= wdt_timer_pkg::MODE_CTRL_RESET;
            period_n <= wdt_timer_pkg::PERIOD_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata;
            end
            if (wr_period) begin
                period_n <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // counter and flags
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt <= wdt_timer_pkg::PERIOD_RESET;
            wdt_done <= 1'b0;
            first_skip <= 1'b0;
            flags <= '0;
        end else begin
            cnt <= next_cnt;
            wdt_done <= next_wdt_done;
            first_skip <= next_first_skip;
            flags <= {next_msf, next_watchdog_expiry_flag, next_countdown_expiry_flag};
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rst_cnt <= '0;
            irq_cnt <= '0;
            irq_n <= 1'b1;
            wdt_rst_n <= 1'b1;
            reg_rdata <= 8'h00;
        end else begin
            rst_cnt <= next_rst_cnt;
            irq_cnt <= next_irq_cnt;
            irq_n <= !irq_active;
            wdt_rst_n <= (next_rst_cnt == '0);
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end
endmodule

// [include/wdt_timer_pkg.sv]
package wdt_timer_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'h01;
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h10;
    localparam logic [7:0] ADDR_PERIOD = 8'h11;

    // ------------------------------------------------------------
    // flag register layout
    // ------------------------------------------------------------
    localparam int FLAG_MSF_BIT = 7;
    localparam int FLAG_WATCHDOG_EXPIRY_FLAG_BIT = 6;
    localparam int FLAG_COUNTDOWN_EXPIRY_FLAG_BIT = 3;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CTRL_RESET = 8'h03;
    localparam logic [7:0] PERIOD_RESET = 8'h00;

    // ------------------------------------------------------------
    // tick chain
    // ------------------------------------------------------------
    localparam int FAST_TICK_HZ = 4096;
    localparam int DIV_TO_64HZ = 64;
    localparam int DIV_TO_1HZ = 64;
    localparam int DIV_TO_MINUTE = 60;
    localparam int CLK_HZ_DEFAULT = 100_000_000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RST_W_FAST_NS = 244_000;
    localparam int RST_W_SLOW_NS = 15_625_000;
    localparam int IRQ_PULSE_NS = 10_000;
    localparam int RST_W_FAST_CYC = (RST_W_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_W_SLOW_CYC = (RST_W_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 21;
    localparam int IRQ_CNT_W = 10;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FN_OFF,
        FN_COUNTDOWN,
        FN_WDT_IRQ,
        FN_WDT_RST
    } timer_fn_e;

    typedef enum logic [1:0] {
        SRC_4096HZ,
        SRC_64HZ,
        SRC_1HZ,
        SRC_1_60HZ
    } tick_src_e;

    typedef struct packed {
        timer_fn_e timer_function_select;
        logic irq_pulse_style;
        logic [2:0] unused;
        tick_src_e tick_source_select;
    } mode_ctrl_s;

    typedef struct packed {
        logic min_sec_flag;
        logic watchdog_expiry_flag;
        logic countdown_expiry_flag;
    } flags_s;

endpackage

// [src/tick_divider.sv]
`timescale 1ns/1ps
module tick_divider #(
    parameter int RATIO = 64
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // ticks
    input wire logic in_tick,
    output logic out_tick
);
    localparam int CW = $clog2(RATIO);
    localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

    logic [CW-1:0] cnt;
    wire wrap = in_tick && (cnt == LAST);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt <= '0;
            out_tick <= 1'b0;
        end else begin
            out_tick <= wrap;
            if (wrap) begin
                cnt <= '0;
            end else if (in_tick) begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule

// [tb/watchdog_countdown_timer_monitor.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module watchdog_countdown_timer_monitor #(
    parameter int RST_FAST_CYC = wdt_timer_pkg::RST_W_FAST_CYC,
    parameter int RST_SLOW_CYC = wdt_timer_pkg::RST_W_SLOW_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic irq_n,
    input wire logic wdt_rst_n
);
    logic [7:0] ctrl;
    logic [20:0] rst_lo;
    logic [10:0] irq_lo;
    wire per_wr = reg_wr && reg_addr == 8'h11;
    wire [20:0] rst_exp = (ctrl[1:0] == 2'b00) ? 21'(RST_FAST_CYC) : 21'(RST_SLOW_CYC);
    // shadow of the control register; unused bits read back as zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ctrl <= 8'h03;
            rst_lo <= '0;
            irq_lo <= '0;
        end else begin
            if (reg_wr && reg_addr == 8'h10) ctrl <= reg_wdata & 8'he3;
            rst_lo <= wdt_rst_n ? '0 : rst_lo + 21'h1;
            irq_lo <= irq_n ? '0 : irq_lo + 11'h1;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // off mode only: a running count may tick between load and read
    sequence s_per_wr_off;
        per_wr && ctrl[7:6] == 2'b00;
    endsequence
    sequence s_per_rd;
        reg_rd && !reg_wr && reg_addr == 8'h11;
    endsequence
    AST_PERIOD_READBACK: assert property (s_per_wr_off ##2 s_per_rd |=>
        reg_rdata == $past(reg_wdata, 3)) else $error("period readback wrong");
    AST_RST_RELEASE: assert property (per_wr && reg_wdata != 8'h00 |=> wdt_rst_n)
        else $error("reset output held after period load");
    AST_ZERO_STOPS: assert property (per_wr && reg_wdata == 8'h00 |=> wdt_rst_n [*2])
        else $error("reset output active after zero load");
    AST_RST_WIDTH: assert property ($rose(wdt_rst_n) && !$past(per_wr) |-> rst_lo == rst_exp)
        else $error("reset pulse width wrong");
    AST_RST_MODE: assert property ($fell(wdt_rst_n) |-> ctrl[7:6] == 2'b11)
        else $error("reset pulse outside reset mode");
    AST_CTRL_READ: assert property (reg_rd && !reg_wr && reg_addr == 8'h10 |=> reg_rdata == ctrl)
        else $error("control readback wrong");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_IRQ_PULSE: assert property ($rose(irq_n) && ctrl[5] && ctrl[7:6] != 2'b10 |->
        irq_lo == 11'(wdt_timer_pkg::IRQ_PULSE_CYC)) else $error("irq pulse width wrong");
endmodule

bind watchdog_countdown_timer watchdog_countdown_timer_monitor #(
    .RST_FAST_CYC(RST_FAST_CYC),
    .RST_SLOW_CYC(RST_SLOW_CYC)
) i_watchdog_countdown_timer_monitor (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_n(irq_n),
    .wdt_rst_n(wdt_rst_n)
);

// [tb/wdt_host_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// host side: watches the interrupt and reset inputs
// ------------------------------------------------------------
module wdt_host_model (
    // clock
    input wire logic core_clk,
    // pins from the timer
    input wire logic irq_n,
    input wire logic wdt_rst_n,
    // observations
    output logic [20:0] rst_width,
    output logic [15:0] irq_falls
);
    logic [20:0] low_run;
    logic irq_prev;
    initial begin
        rst_width = '0;
        irq_falls = '0;
        low_run = '0;
        irq_prev = 1'b1;
    end
    // width latched when the reset pin releases
    always @(posedge core_clk) begin
        if (wdt_rst_n === 1'b0) begin
            low_run <= low_run + 21'h1;
        end else begin
            if (low_run != '0) rst_width <= low_run;
            low_run <= '0;
        end
        if (irq_n === 1'b0 && irq_prev === 1'b1) irq_falls <= irq_falls + 16'h1;
        irq_prev <= irq_n;
    end
endmodule

// [tb/watchdog_countdown_timer_tb.sv]
`timescale 1ns/1ps
module watchdog_countdown_timer_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic second_event_enable = 1'b0;
    logic minute_event_enable = 1'b0;
    logic countdown_irq_enable = 1'b0;
    logic [7:0] reg_rdata;
    logic irq_n;
    logic wdt_rst_n;
    logic [20:0] rst_width;
    logic [15:0] irq_falls;
    logic [15:0] falls0;
    logic [7:0] v;
    int n_mismatch = 0;
    int checks = 0;
    int n;
    initial forever #5 core_clk = ~core_clk;
    // short counts keep the run small: 4096 Hz tick every 2 clocks
    watchdog_countdown_timer #(.CLK_HZ(8192), .RST_FAST_CYC(4), .RST_SLOW_CYC(20))
        i_watchdog_countdown_timer (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .second_event_enable(second_event_enable),
        .minute_event_enable(minute_event_enable),
        .countdown_irq_enable(countdown_irq_enable), .irq_n(irq_n), .wdt_rst_n(wdt_rst_n));
    wdt_host_model i_wdt_host_model (.core_clk(core_clk), .irq_n(irq_n),
        .wdt_rst_n(wdt_rst_n), .rst_width(rst_width), .irq_falls(irq_falls));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // each access leaves one idle cycle so strobes never toggle twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        rd(a);
        chk(what, 21'(exp), 21'(v));
    endtask
    task automatic wait_lo(input bit rst_pin, input int lim);
        n = 0;
        while ((rst_pin ? wdt_rst_n : irq_n) !== 1'b0 && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= lim) begin
            n_mismatch++;
            $display("mismatch wait expected 0 seen 1");
            summarize();
        end
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge core_clk);
        sys_rst = 1'b0;
        rdc(8'h10, 8'h03, "ctrl reset");
        rdc(8'h11, 8'h00, "period reset");
        rdc(8'h01, 8'h00, "flags reset");
        rdc(8'h5a, 8'h00, "unmapped");
        for (int f = 0; f < 4; f++) begin
            wr(8'h10, {f[1:0], f[0], 3'b111, ~f[1:0]});
            rdc(8'h10, {f[1:0], f[0], 3'b000, ~f[1:0]}, "ctrl field");
        end
        wr(8'h10, 8'h00);
        wr(8'h11, 8'ha5);
        rdc(8'h11, 8'ha5, "period");
        wr(8'h11, 8'h03);
        countdown_irq_enable = 1'b1;
        wr(8'h10, 8'h40);
        wait_lo(1'b0, 40);
        // 3 to 4 ticks of 2 clocks, plus irq lag, wait starts one clock in
        chk("first period", 21'h1, 21'(n >= 7 && n <= 8));
        wr(8'h10, 8'h00);
        rdc(8'h01, 8'h08, "countdown flag");
        wr(8'h01, 8'hff);
        rdc(8'h01, 8'h08, "flag kept");
        wr(8'h01, 8'hb7);
        rdc(8'h01, 8'h00, "flag cleared");
        countdown_irq_enable = 1'b0;
        falls0 = irq_falls;
        wr(8'h10, 8'h40);
        repeat (40) @(negedge core_clk);
        chk("masked irq", 21'(falls0), 21'(irq_falls));
        wr(8'h10, 8'h00);
        rdc(8'h01, 8'h08, "flag while masked");
        wr(8'h01, 8'hb7);
        wr(8'h11, 8'h00);
        wr(8'h10, 8'h40);
        repeat (40) @(negedge core_clk);
        rdc(8'h01, 8'h00, "zero halts");
        wr(8'h10, 8'h00);
        wr(8'h11, 8'd200);
        wr(8'h10, 8'h40);
        repeat (20) @(negedge core_clk);
        for (int i = 0; i < 4; i++) begin
            rd(8'h11);
            n = v;
            rd(8'h11);
            if (v == n) break;
        end
        chk("live count", 21'h1, 21'(v < 8'd200 && v > 8'd170));
        wr(8'h11, 8'h02);
        repeat (10) @(negedge core_clk);
        rdc(8'h01, 8'h08, "new n at once");
        wr(8'h10, 8'h00);
        wr(8'h11, 8'h04);
        wr(8'h10, 8'h80);
        wait_lo(1'b0, 20);
        chk("expiry delay", 21'h1, 21'(n >= 3 && n <= 8));
        repeat (30) @(negedge core_clk);
        chk("irq held", 21'h0, 21'(irq_n));
        rdc(8'h11, 8'h01, "stopped count");
        wr(8'h01, 8'h00);
        rdc(8'h01, 8'h40, "wd flag");
        rdc(8'h01, 8'h00, "wd flag read clear");
        wr(8'h01, 8'hff);
        rdc(8'h01, 8'h00, "wd flag write");
        wr(8'h11, 8'h04);
        wait_lo(1'b0, 20);
        wr(8'h11, 8'h00);
        repeat (30) @(negedge core_clk);
        chk("wd stopped", 21'h1, 21'(irq_n));
        wr(8'h10, 8'hc0);
        wr(8'h11, 8'h02);
        wait_lo(1'b1, 20);
        repeat (10) @(negedge core_clk);
        chk("rst fast", 21'd4, rst_width);
        chk("irq in reset mode", 21'h1, 21'(irq_n));
        wr(8'h11, 8'h00);
        wr(8'h10, 8'hc1);
        wr(8'h11, 8'h01);
        wait_lo(1'b1, 300);
        repeat (30) @(negedge core_clk);
        chk("rst slow", 21'd20, rst_width);
        wr(8'h11, 8'h00);
        wr(8'h10, 8'h20);
        second_event_enable = 1'b1;
        wait_lo(1'b0, 9000);
        rdc(8'h01, 8'h80, "sec flag");
        repeat (1000) @(negedge core_clk);
        chk("pulse ended", 21'h1, 21'(irq_n));
        wr(8'h10, 8'h00);
        chk("steady low", 21'h0, 21'(irq_n));
        wr(8'h01, 8'h7f);
        chk("steady released", 21'h1, 21'(irq_n));
        summarize();
    end
endmodule
